// >>> hdl/motor_starter_command_status.sv
// command words, network outputs and serial/fieldbus monitors of a soft starter
// assumes all inputs synchronous to mclk; sources present raw 16-bit words
//
// Notes on behaviour
// - six 16-bit command words; inactive sources get run and inching bits cleared.
// - bit 0: 0 ramped stop, 1 ramped start.
// - bit 1: 0 general disable, 1 general enable.
// - bit 2: 1 requests inching, 0 none.
// - bit 3: 0 clockwise, 1 counterclockwise.
// - bit 4: 0 local, 1 remote; bits 5 and 6 reserved.
// - fault reset only on rising edge of bit 7 while a fault is active.
// - digital-input word also has bit 8 brake, bit 9 emergency start.
// - other sources use bits 0 to 4 and 7 only.
// - network output bits 0..2 drive digital outputs one to three.
// - 10-bit analog output value, 0 is 0 percent, 1023 full scale.
// - serial state 0 absent, 1 detected, 2 timeout alarm or fault.
// - 16-bit received and transmitted telegram counters.
// - 16-bit counter of received messages with bad check field.
// - 16-bit counter of bytes with other reception errors.
// - all serial counters wrap to zero past maximum.
// - fieldbus module type coded 0..31, zero none, five named codes.
// - fieldbus state 0 setup, 1 init, 2 wait, then 3 idle or 4 online.
// - fieldbus state 7 serious error, 8 access error.
`timescale 1ns/1ps

module motor_starter_command_status
   import starter_cmd_pkg::*;
#(
   parameter int NUM_SOURCES = 6
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // register port
   input wire starter_cmd_pkg::reg_req_t reg_req,
   output logic [15:0] reg_rdata,
   // command sources
   input wire logic [15:0] src_cmd [6],
   input wire logic [2:0] active_source,
   input wire logic fault_active,
   // serial accessory
   input wire logic serial_present,
   input wire logic serial_timeout_alarm,
   input wire logic serial_timeout_fault,
   input wire starter_cmd_pkg::serial_evt_t serial_evt,
   // fieldbus module
   input wire logic [4:0] fieldbus_id,
   input wire logic fb_config_done,
   input wire logic fb_init_done,
   input wire logic fb_master_idle,
   input wire logic fb_master_online,
   input wire logic fb_master_lost,
   input wire logic fb_exception,
   input wire logic fb_access_error,
   input wire logic fb_reinit,
   // outputs to the drive
   output starter_cmd_pkg::motor_cmd_t motor_cmd,
   output logic fault_reset_pulse,
   output logic digital_output_one,
   output logic digital_output_two,
   output logic digital_output_three,
   output logic [9:0] analog_output
);
   import starter_cmd_pkg::*;

   if (NUM_SOURCES != NUM_SRC) begin : g_chk
      $error("NUM_SOURCES must be 6");
   end

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [15:0] wrap_inc(input logic [15:0] v);
      wrap_inc = v + 16'h0001;
   endfunction

   function automatic logic [15:0] src_mask(input int idx);
      src_mask = (idx == 0) ? MASK_CMD_DIGITAL : MASK_CMD_OTHER;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // command words
   logic [15:0] cmd_q [6];
   logic [2:0] active_q;
   logic [15:0] cmd_d [6];

   always_comb begin
      for (int i = 0; i < 6; i++) begin
         cmd_d[i] = src_cmd[i] & src_mask(i);
         if (active_source != 3'(i)) begin
            cmd_d[i] = cmd_d[i] & ~MASK_RUN_INCH;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < 6; i++) begin
            cmd_q[i] <= RST_WORD;
         end
         active_q <= RST_ACTIVE_SOURCE;
      end else begin
         for (int i = 0; i < 6; i++) begin
            cmd_q[i] <= cmd_d[i];
         end
         active_q <= active_source;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // decoded motor command from the active source, brake and emergency from the digital-input word, fault reset from any source
   logic [15:0] act_word;
   logic [5:0] reset_bit_q;
   logic [5:0] reset_rise;

   always_comb begin
      act_word = (active_q < 3'h6) ? cmd_q[active_q] : RST_WORD;
      for (int i = 0; i < 6; i++) begin
         reset_rise[i] = cmd_q[i][BIT_FAULT_RESET] & ~reset_bit_q[i];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         motor_cmd <= '0;
      end else begin
         motor_cmd.run <= act_word[BIT_RUN];
         motor_cmd.enable <= act_word[BIT_ENABLE];
         motor_cmd.inching <= act_word[BIT_INCHING];
         motor_cmd.direction <= act_word[BIT_DIRECTION];
         motor_cmd.location <= act_word[BIT_LOCATION];
         motor_cmd.brake <= cmd_q[0][BIT_BRAKE];
         motor_cmd.emergency <= cmd_q[0][BIT_EMERGENCY];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         reset_bit_q <= 6'h00;
         fault_reset_pulse <= 1'b0;
      end else begin
         for (int i = 0; i < 6; i++) begin
            reset_bit_q[i] <= cmd_q[i][BIT_FAULT_RESET];
         end
         fault_reset_pulse <= (|reset_rise) & fault_active;
      end
   end

   chk_fault_reset_edge: assert property (@(posedge mclk) disable iff (rst)
      fault_reset_pulse |-> $past(fault_active) && $past(|reset_rise))
      else $error("fault reset without rising edge");

   chk_inactive_cleared: assert property (@(posedge mclk) disable iff (rst)
      $past(active_source) != 3'h1 |-> (cmd_q[1] & MASK_RUN_INCH) == 16'h0000)
      else $error("inactive source kept run or inching");

   chk_run_follows: assert property (@(posedge mclk) disable iff (rst)
      ##1 active_q == 3'h0 |=> motor_cmd.run == $past(cmd_q[0][0]))
      else $error("run bit not decoded");

   ////////////////////////////////////////////////////////////////////////////
   // network outputs
   logic [15:0] dout_q;
   logic [9:0] aout_q;
   logic wr_dout;
   logic wr_aout;

   assign wr_dout = reg_req.wr && reg_req.addr == OFS_NETWORK_DIGITAL_OUTPUTS;
   assign wr_aout = reg_req.wr && reg_req.addr == OFS_NETWORK_ANALOG_OUTPUT;

   always_ff @(posedge mclk) begin
      if (rst) begin
         dout_q <= RST_WORD;
         aout_q <= 10'h000;
      end else begin
         if (wr_dout) begin
            dout_q <= reg_req.wdata & MASK_DOUT;
         end
         if (wr_aout) begin
            aout_q <= reg_req.wdata[9:0] & ANALOG_FULL_SCALE;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         digital_output_one <= 1'b0;
         digital_output_two <= 1'b0;
         digital_output_three <= 1'b0;
         analog_output <= 10'h000;
      end else begin
         digital_output_one <= dout_q[0];
         digital_output_two <= dout_q[1];
         digital_output_three <= dout_q[2];
         analog_output <= aout_q;
      end
   end

   chk_dout_drive: assert property (@(posedge mclk) disable iff (rst)
      wr_dout |-> ##2 digital_output_two == $past(reg_req.wdata[1], 2))
      else $error("digital output two not driven");

   chk_aout_drive: assert property (@(posedge mclk) disable iff (rst)
      wr_aout |-> ##2 analog_output == $past(reg_req.wdata[9:0], 2))
      else $error("analog output not driven");

   ////////////////////////////////////////////////////////////////////////////
   // serial accessory monitor
   logic [1:0] ser_state_q;
   logic [15:0] rx_cnt_q;
   logic [15:0] tx_cnt_q;
   logic [15:0] bad_cnt_q;
   logic [15:0] byte_err_q;

   always_ff @(posedge mclk) begin
      if (rst) begin
         ser_state_q <= SER_OFF;
      end else if (!serial_present) begin
         ser_state_q <= SER_OFF;
      end else if (serial_timeout_alarm || serial_timeout_fault) begin
         ser_state_q <= SER_TIMEOUT;
      end else begin
         ser_state_q <= SER_ON;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         rx_cnt_q <= RST_WORD;
         tx_cnt_q <= RST_WORD;
      end else begin
         if (serial_evt.rx_telegram) begin
            rx_cnt_q <= wrap_inc(rx_cnt_q);
         end
         if (serial_evt.tx_telegram) begin
            tx_cnt_q <= wrap_inc(tx_cnt_q);
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         bad_cnt_q <= RST_WORD;
         byte_err_q <= RST_WORD;
      end else begin
         if (serial_evt.bad_check) begin
            bad_cnt_q <= wrap_inc(bad_cnt_q);
         end
         if (serial_evt.byte_error) begin
            byte_err_q <= wrap_inc(byte_err_q);
         end
      end
   end

   chk_rx_count: assert property (@(posedge mclk) disable iff (rst)
      serial_evt.rx_telegram |=> rx_cnt_q == $past(rx_cnt_q) + 16'h0001)
      else $error("rx counter did not step");

   chk_bad_count: assert property (@(posedge mclk) disable iff (rst)
      !serial_evt.bad_check |=> $stable(bad_cnt_q))
      else $error("bad check counter moved");

   chk_byte_wrap: assert property (@(posedge mclk) disable iff (rst)
      serial_evt.byte_error && byte_err_q == 16'hFFFF |=> byte_err_q == 16'h0000)
      else $error("byte error counter did not wrap");

   chk_ser_timeout: assert property (@(posedge mclk) disable iff (rst)
      serial_present && serial_timeout_fault |=> ser_state_q == SER_TIMEOUT)
      else $error("timeout not reported");

   ////////////////////////////////////////////////////////////////////////////
   // fieldbus module monitor
   logic [4:0] fb_type_q;
   fb_state_t fb_state_q;
   logic [15:0] fb_code;

   always_ff @(posedge mclk) begin
      if (rst) begin
         fb_type_q <= FB_NONE;
      end else begin
         case (fieldbus_id)
            FB_TYPE_A, FB_TYPE_B, FB_TYPE_C, FB_TYPE_D, FB_TYPE_E: begin
               fb_type_q <= fieldbus_id;
            end
            default: begin
               fb_type_q <= FB_NONE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst || fb_type_q == FB_NONE) begin
         fb_state_q <= FB_SETUP;
      end else if (fb_access_error) begin
         fb_state_q <= FB_ACCESS_ERROR;
      end else if (fb_exception) begin
         fb_state_q <= FB_EXCEPTION;
      end else begin
         case (fb_state_q)
            FB_SETUP: begin
               if (fb_config_done) fb_state_q <= FB_INIT;
            end
            FB_INIT: begin
               if (fb_init_done) fb_state_q <= FB_WAIT_MASTER;
            end
            FB_WAIT_MASTER, FB_IDLE, FB_ONLINE: begin
               if (fb_master_lost) fb_state_q <= FB_WAIT_MASTER;
               else if (fb_master_online) fb_state_q <= FB_ONLINE;
               else if (fb_master_idle) fb_state_q <= FB_IDLE;
            end
            FB_EXCEPTION, FB_ACCESS_ERROR: begin
               if (fb_reinit) fb_state_q <= FB_SETUP;
            end
            default: begin
               fb_state_q <= FB_SETUP;
            end
         endcase
      end
   end

   always_comb begin
      case (fb_state_q)
         FB_SETUP: fb_code = CODE_SETUP;
         FB_INIT: fb_code = CODE_INIT;
         FB_WAIT_MASTER: fb_code = CODE_WAIT;
         FB_IDLE: fb_code = CODE_IDLE;
         FB_ONLINE: fb_code = CODE_ONLINE;
         FB_EXCEPTION: fb_code = CODE_EXCEPTION;
         FB_ACCESS_ERROR: fb_code = CODE_ACCESS_ERROR;
         default: fb_code = CODE_SETUP;
      endcase
   end

   chk_fb_order: assert property (@(posedge mclk) disable iff (rst)
      fb_state_q == FB_ONLINE && !$past(fb_state_q == FB_ONLINE)
      |-> $past(fb_state_q) inside {FB_WAIT_MASTER, FB_IDLE})
      else $error("online reached out of order");

   chk_fb_access: assert property (@(posedge mclk) disable iff (rst)
      fb_access_error && fb_type_q != FB_NONE |=> fb_code == CODE_ACCESS_ERROR)
      else $error("access error not reported");

   ////////////////////////////////////////////////////////////////////////////
   // register read port
   always_ff @(posedge mclk) begin
      if (rst) begin
         reg_rdata <= RST_WORD;
      end else if (reg_req.rd) begin
         case (reg_req.addr)
            OFS_NETWORK_DIGITAL_OUTPUTS: reg_rdata <= dout_q;
            OFS_NETWORK_ANALOG_OUTPUT: reg_rdata <= {6'h00, aout_q};
            OFS_SERIAL_INTERFACE_STATE: reg_rdata <= {14'h0000, ser_state_q};
            OFS_SERIAL_RX_COUNT: reg_rdata <= rx_cnt_q;
            OFS_SERIAL_TX_COUNT: reg_rdata <= tx_cnt_q;
            OFS_SERIAL_BAD_CHECK_COUNT: reg_rdata <= bad_cnt_q;
            OFS_SERIAL_BYTE_ERROR_COUNT: reg_rdata <= byte_err_q;
            OFS_FIELDBUS_MODULE_TYPE: reg_rdata <= {11'h000, fb_type_q};
            OFS_FIELDBUS_MODULE_STATE: reg_rdata <= fb_code;
            OFS_ACTIVE_SOURCE: reg_rdata <= {13'h0000, active_q};
            default: begin
               if (reg_req.addr < 5'h06) reg_rdata <= cmd_q[reg_req.addr[2:0]];
               else reg_rdata <= RST_WORD;
            end
         endcase
      end else begin
         reg_rdata <= RST_WORD;
      end
   end

endmodule // motor_starter_command_status

// >>> hdl/starter_cmd_pkg.sv
// constants, register map and carrier types of the starter command/status bank
// assumes a single clock domain and a simple strobe register port
package starter_cmd_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam int NUM_SRC = 6;
   // source indices
   localparam logic [2:0] SRC_DIGITAL_INPUTS = 3'h0;
   localparam logic [2:0] SRC_PANEL_KEYS = 3'h1;
   localparam logic [2:0] SRC_USB_PORT = 3'h2;
   localparam logic [2:0] SRC_LOGIC_PROGRAM = 3'h3;
   localparam logic [2:0] SRC_FIRST_ACCESSORY = 3'h4;
   localparam logic [2:0] SRC_SECOND_ACCESSORY = 3'h5;
   // register offsets (word index on the register port)
   localparam logic [4:0] OFS_CMD_BASE = 5'h00;
   localparam logic [4:0] OFS_NETWORK_DIGITAL_OUTPUTS = 5'h06;
   localparam logic [4:0] OFS_NETWORK_ANALOG_OUTPUT = 5'h07;
   localparam logic [4:0] OFS_SERIAL_INTERFACE_STATE = 5'h08;
   localparam logic [4:0] OFS_SERIAL_RX_COUNT = 5'h09;
   localparam logic [4:0] OFS_SERIAL_TX_COUNT = 5'h0A;
   localparam logic [4:0] OFS_SERIAL_BAD_CHECK_COUNT = 5'h0B;
   localparam logic [4:0] OFS_SERIAL_BYTE_ERROR_COUNT = 5'h0C;
   localparam logic [4:0] OFS_FIELDBUS_MODULE_TYPE = 5'h0D;
   localparam logic [4:0] OFS_FIELDBUS_MODULE_STATE = 5'h0E;
   localparam logic [4:0] OFS_ACTIVE_SOURCE = 5'h0F;
   // command word fields
   localparam int BIT_RUN = 0;
   localparam int BIT_ENABLE = 1;
   localparam int BIT_INCHING = 2;
   localparam int BIT_DIRECTION = 3;
   localparam int BIT_LOCATION = 4;
   localparam int BIT_FAULT_RESET = 7;
   localparam int BIT_BRAKE = 8;
   localparam int BIT_EMERGENCY = 9;
   localparam logic [15:0] MASK_CMD_DIGITAL = 16'h039F;
   localparam logic [15:0] MASK_CMD_OTHER = 16'h009F;
   localparam logic [15:0] MASK_RUN_INCH = 16'h0005;
   localparam logic [15:0] MASK_DOUT = 16'h0007;
   localparam logic [9:0] ANALOG_FULL_SCALE = 10'h3FF;
   // reset values
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [2:0] RST_ACTIVE_SOURCE = 3'h0;
   // serial interface state codes
   localparam logic [1:0] SER_OFF = 2'h0;
   localparam logic [1:0] SER_ON = 2'h1;
   localparam logic [1:0] SER_TIMEOUT = 2'h2;
   // fieldbus module type codes
   localparam logic [4:0] FB_NONE = 5'h00;
   localparam logic [4:0] FB_TYPE_A = 5'h10;
   localparam logic [4:0] FB_TYPE_B = 5'h11;
   localparam logic [4:0] FB_TYPE_C = 5'h13;
   localparam logic [4:0] FB_TYPE_D = 5'h15;
   localparam logic [4:0] FB_TYPE_E = 5'h17;
   // fieldbus module state codes, gray along setup..wait..idle..online
   typedef enum logic [3:0] {
      FB_SETUP = 4'h0,
      FB_INIT = 4'h1,
      FB_WAIT_MASTER = 4'h3,
      FB_IDLE = 4'h2,
      FB_ONLINE = 4'h6,
      FB_EXCEPTION = 4'h7,
      FB_ACCESS_ERROR = 4'h5
   } fb_state_t;
   localparam logic [15:0] CODE_SETUP = 16'h0000;
   localparam logic [15:0] CODE_INIT = 16'h0001;
   localparam logic [15:0] CODE_WAIT = 16'h0002;
   localparam logic [15:0] CODE_IDLE = 16'h0003;
   localparam logic [15:0] CODE_ONLINE = 16'h0004;
   localparam logic [15:0] CODE_EXCEPTION = 16'h0007;
   localparam logic [15:0] CODE_ACCESS_ERROR = 16'h0008;
   // carriers
   typedef struct packed {
      logic wr;
      logic rd;
      logic [4:0] addr;
      logic [15:0] wdata;
   } reg_req_t;
   typedef struct packed {
      logic rx_telegram;
      logic tx_telegram;
      logic bad_check;
      logic byte_error;
   } serial_evt_t;
   typedef struct packed {
      logic run;
      logic enable;
      logic inching;
      logic direction;
      logic location;
      logic brake;
      logic emergency;
   } motor_cmd_t;
endpackage

// >>> testbench/far_side_model.sv
// far side: serial telegram events and fieldbus master events
// assumes bench requests last one mclk cycle, driven just after the edge
`timescale 1ns/1ps

module far_side_model
   import starter_cmd_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // requests from the bench
   input wire logic ser_go,
   input wire logic [1:0] ser_kind,
   input wire logic [16:0] ser_count,
   input wire logic slow,
   input wire logic [7:0] fb_fire,
   // events toward the starter
   output starter_cmd_pkg::serial_evt_t serial_evt,
   output logic ser_busy,
   output logic [7:0] fb_events
);
   logic [16:0] left_q;
   logic [1:0] kind_q;
   logic tick_q;
   logic fire;
   ////////////////////////////////////////////////////////////
   // one event a cycle, every other cycle when slow
   assign fire = (left_q != 17'h00000) && (!slow || tick_q);
   assign ser_busy = ser_go || (left_q != 17'h00000);
   assign serial_evt = '{rx_telegram: fire && (kind_q == 2'h0),
      tx_telegram: fire && (kind_q == 2'h1),
      bad_check: fire && (kind_q == 2'h2),
      byte_error: fire && (kind_q == 2'h3)};

   always_ff @(posedge mclk) begin
      if (rst) begin
         left_q <= 17'h00000;
         kind_q <= 2'h0;
      end else if (ser_go) begin
         left_q <= ser_count;
         kind_q <= ser_kind;
      end else if (fire) begin
         left_q <= left_q - 17'h00001;
      end
   end

   always_ff @(posedge mclk) begin
      tick_q <= !rst && !tick_q;
   end

   // fieldbus master events, one cycle each
   always_ff @(posedge mclk) begin
      fb_events <= rst ? 8'h00 : fb_fire;
   end
endmodule // far_side_model

// >>> testbench/motor_starter_command_status_test.sv
// self-checking bench of the starter command/status bank
// assumes the package and far_side_model compiled first
`timescale 1ns/1ps

`define CHK(nm, e, g) \
   begin \
      tests_run++; \
      if ((g) !== (e)) begin \
         bad_count++; \
         $display("wrong value %s expected %h seen %h", nm, e, g); \
      end \
   end

module motor_starter_command_status_test;
   import starter_cmd_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   reg_req_t reg_req = '0;
   logic [15:0] reg_rdata;
   logic [15:0] src_cmd [6] = '{default: 16'h0000};
   logic [2:0] active_source = 3'h0;
   logic fault_active = 1'b0;
   logic present = 1'b0;
   logic alarm = 1'b0;
   logic tfault = 1'b0;
   serial_evt_t serial_evt;
   logic [4:0] fieldbus_id = 5'h00;
   logic [7:0] fb_events;
   motor_cmd_t motor_cmd;
   logic pulse;
   logic [2:0] dout;
   logic [9:0] aout;
   logic ser_go = 1'b0;
   logic [1:0] ser_kind = 2'h0;
   logic [16:0] ser_count = 17'h00000;
   logic slow = 1'b0;
   logic ser_busy;
   logic [7:0] fb_fire = 8'h00;
   logic [15:0] d;
   int bad_count = 0;
   int tests_run = 0;
   logic [7:0] fm [12] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h08, 8'h20, 8'h80,
      8'h01, 8'h60, 8'h80, 8'h01};
   logic [3:0] fc [12] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h2, 4'h4, 4'h7, 4'h0, 4'h1, 4'h8,
      4'h0, 4'h1};

   motor_starter_command_status #(.NUM_SOURCES(6)) motor_starter_command_status_inst (
      .mclk(mclk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .src_cmd(src_cmd), .active_source(active_source), .fault_active(fault_active),
      .serial_present(present), .serial_timeout_alarm(alarm),
      .serial_timeout_fault(tfault), .serial_evt(serial_evt), .fieldbus_id(fieldbus_id),
      .fb_config_done(fb_events[0]), .fb_init_done(fb_events[1]),
      .fb_master_idle(fb_events[2]), .fb_master_online(fb_events[3]),
      .fb_master_lost(fb_events[4]), .fb_exception(fb_events[5]),
      .fb_access_error(fb_events[6]), .fb_reinit(fb_events[7]),
      .motor_cmd(motor_cmd), .fault_reset_pulse(pulse), .digital_output_one(dout[0]),
      .digital_output_two(dout[1]), .digital_output_three(dout[2]), .analog_output(aout)
   );

   far_side_model far_side_model_inst (
      .mclk(mclk), .rst(rst), .ser_go(ser_go), .ser_kind(ser_kind),
      .ser_count(ser_count), .slow(slow), .fb_fire(fb_fire), .serial_evt(serial_evt),
      .ser_busy(ser_busy), .fb_events(fb_events)
   );

   always #5 mclk = ~mclk;
   ////////////////////////////////////////////////////////////
   function automatic logic [15:0] exp_cmd(input int s);
      logic [15:0] w;
      w = src_cmd[s] & ((s == 0) ? MASK_CMD_DIGITAL : MASK_CMD_OTHER);
      if (int'(active_source) != s) w = w & ~MASK_RUN_INCH;
      return w;
   endfunction

   function automatic motor_cmd_t exp_motor();
      logic [15:0] w;
      logic [15:0] b;
      // brake and emergency follow the digital-input word whatever the active source
      b = exp_cmd(0);
      w = (active_source > 3'h5) ? 16'h0000 : exp_cmd(int'(active_source));
      return motor_cmd_t'({w[0], w[1], w[2], w[3], w[4], b[8], b[9]});
   endfunction

   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge mclk);
      reg_req <= '0;
      @(posedge mclk);
   endtask

   task automatic rd(input logic [4:0] a);
      reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge mclk);
      reg_req <= '0;
      @(negedge mclk);
      d = reg_rdata;
      @(posedge mclk);
   endtask

   task automatic pulses(input logic [3:0] n);
      logic [3:0] c;
      c = 4'h0;
      repeat (6) begin
         @(negedge mclk);
         c = c + {3'h0, pulse};
      end
      @(posedge mclk);
      `CHK("reset pulses", n, c)
   endtask

   task automatic send(input logic [1:0] k, input logic [16:0] n, input logic s);
      ser_go <= 1'b1;
      ser_kind <= k;
      ser_count <= n;
      slow <= s;
      @(posedge mclk);
      ser_go <= 1'b0;
      repeat (70000) begin
         @(negedge mclk);
         if (ser_busy === 1'b0) break;
      end
      if (ser_busy !== 1'b0) begin
         bad_count++;
         test_done();
      end
      @(posedge mclk);
   endtask

   task automatic note(input string nm);
      $display("end of test %s", nm);
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      logic [15:0] v;
      void'($urandom(92));
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      for (int a = 0; a < 17; a++) begin
         rd((a == 16) ? 5'h1F : 5'(a));
         `CHK("reset value", 16'h0000, d)
      end
      note("reset");
      for (int n = 0; n < 24; n++) begin
         for (int s = 0; s < 6; s++) src_cmd[s] <= (n < 2) ? 16'hFFFF : 16'($urandom);
         active_source <= (n < 2) ? 3'(n * 7) : 3'($urandom_range(7, 0));
         repeat (3) @(posedge mclk);
         @(negedge mclk);
         `CHK("motor_cmd", exp_motor(), motor_cmd)
         @(posedge mclk);
         for (int s = 0; s < 6; s++) begin
            rd(5'(s));
            `CHK("command word", exp_cmd(s), d)
         end
         rd(OFS_ACTIVE_SOURCE);
         `CHK("active source", {13'h0000, active_source}, d)
      end
      note("command words");
      src_cmd <= '{default: 16'h0000};
      active_source <= 3'h1;
      fault_active <= 1'b1;
      repeat (3) @(posedge mclk);
      src_cmd[2] <= 16'h0080;
      pulses(4'h1);
      pulses(4'h0);
      src_cmd[2] <= 16'h0000;
      fault_active <= 1'b0;
      repeat (3) @(posedge mclk);
      src_cmd[2] <= 16'h0080;
      pulses(4'h0);
      note("fault reset");
      for (int n = 0; n < 8; n++) begin
         v = (n == 0) ? 16'hFFFF : (n == 1) ? 16'h0000 : 16'($urandom);
         wr(OFS_NETWORK_DIGITAL_OUTPUTS, v);
         wr(OFS_NETWORK_ANALOG_OUTPUT, ~v);
         rd(OFS_NETWORK_DIGITAL_OUTPUTS);
         `CHK("output word", v & MASK_DOUT, d)
         rd(OFS_NETWORK_ANALOG_OUTPUT);
         `CHK("analog word", {6'h00, ~v[9:0]}, d)
         @(negedge mclk);
         `CHK("digital outputs", v[2:0], dout)
         `CHK("analog output", ~v[9:0], aout)
         @(posedge mclk);
      end
      wr(OFS_SERIAL_RX_COUNT, 16'hFFFF);
      wr(5'h1F, 16'hFFFF);
      rd(OFS_SERIAL_RX_COUNT);
      `CHK("read-only count", 16'h0000, d)
      note("outputs");
      for (int m = 0; m < 8; m++) begin
         {present, alarm, tfault} <= 3'(m);
         repeat (3) @(posedge mclk);
         rd(OFS_SERIAL_INTERFACE_STATE);
         `CHK("serial state", (m < 4) ? 16'h0000 : (m > 4) ? 16'h0002 : 16'h0001, d)
      end
      for (int k = 0; k < 4; k++) begin
         v = (k == 3) ? 16'h0002 : 16'($urandom_range(40, 1));
         send(2'(k), (k == 3) ? 17'h10002 : {1'b0, v}, (k < 3) ? 1'($urandom) : 1'b0);
         rd(OFS_SERIAL_RX_COUNT + 5'(k));
         `CHK("serial counter", v, d)
      end
      note("serial");
      for (int i = 0; i < 32; i++) begin
         fieldbus_id <= 5'(i);
         repeat (2) @(posedge mclk);
         rd(OFS_FIELDBUS_MODULE_TYPE);
         v = (i == 16 || i == 17 || i == 19 || i == 21 || i == 23) ? 16'(i) : 16'h0000;
         `CHK("module type", v, d)
      end
      fieldbus_id <= FB_TYPE_A;
      repeat (2) @(posedge mclk);
      for (int i = 0; i < 12; i++) begin
         fb_fire <= fm[i];
         @(posedge mclk);
         fb_fire <= 8'h00;
         repeat (3) @(posedge mclk);
         rd(OFS_FIELDBUS_MODULE_STATE);
         `CHK("module state", {12'h000, fc[i]}, d)
      end
      fieldbus_id <= FB_NONE;
      repeat (3) @(posedge mclk);
      rd(OFS_FIELDBUS_MODULE_STATE);
      `CHK("module state", 16'h0000, d)
      note("fieldbus");
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rd(OFS_SERIAL_TX_COUNT);
      `CHK("count after reset", 16'h0000, d)
      note("second reset");
      test_done();
   end
endmodule // motor_starter_command_status_test
